// ==== bench/bus_target_model.sv ====
`timescale 1ns/1ps
module bus_target_model
    import ext_bus_pkg::*;
(
    // Bus side
    input  wire logic                    clock,
    input  wire ext_bus_pkg::ctrl_pins_t ctrl_pins,
    input  wire logic                    ctrl_oe,
    input  wire logic [22:0]             addr_out,
    input  wire logic [15:0]             data_out,
    input  wire logic                    data_oe,
    input  wire logic                    wait_complete_n,
    output logic                         ready,
    output logic [15:0]                  data_in,
    // Pace: 0 prompt, 1 slow, 2 wait-complete looped to ready
    input  wire logic [1:0]              ready_mode,
    input  wire logic [2:0]              slow_cycles
);
    // ==========================================================
    // Memory and pacing
    logic [15:0] mem [16];
    logic [2:0]  lag = 3'h0;
    logic        toggle = 1'b0;
    logic        strobe;
    assign strobe = ctrl_oe && !(ctrl_pins.memory_strobe_n && ctrl_pins.io_strobe_n);
    always @(posedge clock) begin
        lag <= strobe ? lag + 3'h1 : 3'h0;
        toggle <= !toggle;
        if (strobe && data_oe && !ctrl_pins.read_write) begin
            mem[addr_out[3:0]] <= data_out;
        end
    end
    assign ready = ready_mode == 2'h2 ? wait_complete_n :
                   ready_mode == 2'h1 ? lag >= slow_cycles : 1'b1;
    // An unstrobed bus shows a pattern that flips every cycle.
    assign data_in = strobe && ctrl_pins.read_write ? mem[addr_out[3:0]] : {16{toggle}} ^ 16'h5a5a;
endmodule

// ==== bench/external_bus_control_monitor.sv ====
`timescale 1ns/1ps
module external_bus_control_monitor
    import ext_bus_pkg::*;
(
    // Observed ports
    input wire logic                    clock,
    input wire logic                    rst_b,
    input wire logic                    bus_busy,
    input wire logic                    access_done,
    input wire ext_bus_pkg::ctrl_pins_t ctrl_pins,
    input wire logic                    ctrl_oe,
    input wire logic [22:0]             addr_out,
    input wire logic                    addr_oe,
    input wire logic                    data_oe,
    input wire logic                    ready,
    input wire logic                    hold_request_n,
    input wire logic                    output_disable_n,
    input wire logic                    hold_acknowledge_n,
    input wire logic                    wait_complete_n,
    input wire logic                    status_oe
);
    // ==========================================================
    // Pin relations
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    logic [2:0] sel;
    assign sel = {ctrl_pins.data_space_select_n, ctrl_pins.program_space_select_n,
                  ctrl_pins.io_space_select_n};
    a_one_select: assert property ($countones(sel) >= 2)
        else $error("two space selects low");
    a_select_addr: assert property ((sel != 3'h7 && $past(sel) != 3'h7) |-> $stable(addr_out))
        else $error("address moved while selected");
    a_write_dir: assert property (data_oe |-> !ctrl_pins.read_write && sel != 3'h7)
        else $error("data driven outside a write");
    a_hold_grant: assert property ((!hold_request_n && !bus_busy) |=>
        !hold_acknowledge_n && !ctrl_oe && !addr_oe && !data_oe)
        else $error("hold not granted from idle");
    a_disable_float: assert property (!$past(output_disable_n) |->
        !ctrl_oe && !addr_oe && !data_oe && !status_oe)
        else $error("outputs driven while disabled");
    a_ready_late: assert property ($rose(wait_complete_n) ##1 ready |=> ##1 access_done)
        else $error("ready high did not end access");
    a_ready_low: assert property ($rose(wait_complete_n) ##1 !ready |=> ##1 !access_done)
        else $error("access ended with ready low");
    a_complete_start: assert property ($fell(wait_complete_n) |-> bus_busy &&
        !(ctrl_pins.memory_strobe_n && ctrl_pins.io_strobe_n))
        else $error("wait complete fell outside wait");
endmodule
bind external_bus_control external_bus_control_monitor u_external_bus_control_monitor (.*);

// ==== bench/test_external_bus_control.sv ====
`timescale 1ns/1ps
module test_external_bus_control;
    import ext_bus_pkg::*;
    // ==========================================================
    // Signals
    logic          clock, rst_b, req_valid, hold_request_n, output_disable_n, ready;
    bus_request_t  request;
    wait_setting_t wait_setting;
    ctrl_pins_t    ctrl_pins;
    logic          bus_busy, access_done, ctrl_oe, addr_oe, data_oe, status_oe;
    logic          hold_acknowledge_n, wait_complete_n, instruction_acquire_n;
    logic [15:0]   read_data, data_out, data_in;
    logic [15:0]   mirror [16];
    logic [22:0]   addr_out;
    logic [1:0]    ready_mode, strobes;
    logic [2:0]    slow_cycles, sel;
    logic [27:0]   pins_seen, pins_exp;
    logic [31:0]   rng;
    int            err_count, comparisons, i;
    assign sel = {ctrl_pins.data_space_select_n, ctrl_pins.program_space_select_n,
                  ctrl_pins.io_space_select_n};
    assign strobes = {ctrl_pins.memory_strobe_n, ctrl_pins.io_strobe_n};
    assign pins_seen = {sel, ctrl_pins.read_write, instruction_acquire_n, addr_out};
    external_bus_control u_external_bus_control (.*);
    bus_target_model u_bus_target_model (.*);
    initial begin
        clock = 1'b0;
        forever #50 clock = !clock;
    end
    // ==========================================================
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic int latency(input int w, input int s, input logic [1:0] m);
        if (w < 2) return w + 2;
        return w + 3 + ((m == 2'h1 && s > w) ? s - w : 0);
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("errors=%0d comparisons=%0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic access(input logic [1:0] sp, input logic wr, input logic [3:0] a,
                          input logic [2:0] w, input logic [1:0] m, input logic [2:0] s);
        int n;
        pins_exp = {~(3'h4 >> sp), !wr, !rng[23], rng[22:4], a};
        @(posedge clock);
        request <= {space_t'(sp), wr, rng[23], rng[22:4], a, rng[31:16]};
        wait_setting <= {sp == 2'h0 ? w : ~w, sp == 2'h1 ? w : ~w, sp == 2'h2 ? w : ~w};
        ready_mode <= m;
        slow_cycles <= s;
        req_valid <= 1'b1;
        @(posedge clock);
        req_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge clock);
            #1;
            n++;
            if (sel !== 3'h7) check(pins_seen, pins_exp);
            if (strobes !== 2'h3) check(strobes, {sp == 2'h2, sp != 2'h2});
        end while (access_done !== 1'b1 && n < 30);
        check(n, latency(w, s, m));
        if (wr) mirror[a] = request.wdata;
        else check(read_data, mirror[a]);
    endtask
    // ==========================================================
    // Sequence
    initial begin
        {rst_b, req_valid, request, wait_setting, ready_mode, slow_cycles} = '0;
        {hold_request_n, output_disable_n} = 2'h3;
        rng = 32'h0000ff6d;
        err_count = 0;
        comparisons = 0;
        repeat (20) @(posedge clock);
        rst_b <= 1'b1;
        for (i = 0; i < 16; i++) begin
            rng = xs(rng);
            access(2'(i % 3), 1'b1, 4'(i), 3'(i), 2'(i / 3 % 3), 3'h5);
        end
        for (i = 0; i < 40; i++) begin
            rng = xs(rng);
            access(2'(rng[25:24] % 3), rng[26], rng[3:0], rng[29:27], 2'(rng[31:30] % 3), rng[9:7]);
        end
        @(posedge clock);
        output_disable_n <= 1'b0;
        repeat (2) @(posedge clock);
        #1 check({ctrl_oe, addr_oe, status_oe, data_oe}, 4'h0);
        @(posedge clock);
        output_disable_n <= 1'b1;
        fork
            access(2'h0, 1'b0, 4'h3, 3'h3, 2'h0, 3'h0);
            begin
                repeat (3) @(posedge clock);
                hold_request_n <= 1'b0;
            end
        join
        repeat (2) @(posedge clock);
        #1 check({hold_acknowledge_n, ctrl_oe, addr_oe, data_oe, bus_busy}, 5'h01);
        @(posedge clock);
        req_valid <= 1'b1;
        repeat (3) @(posedge clock);
        #1 check({access_done, hold_acknowledge_n}, 2'h0);
        @(posedge clock);
        req_valid <= 1'b0;
        hold_request_n <= 1'b1;
        repeat (2) @(posedge clock);
        #1 check({hold_acknowledge_n, ctrl_oe}, 2'h3);
        access(2'h2, 1'b0, 4'h5, 3'h2, 2'h2, 3'h0);
        print_verdict();
    end
    initial begin
        repeat (4000) @(posedge clock);
        err_count++;
        print_verdict();
    end
endmodule

// ==== src/ext_bus_pkg.sv ====
package ext_bus_pkg;

    // ==========================================================
    // Widths
    localparam int ADDR_WIDTH = 23;
    localparam int DATA_WIDTH = 16;
    localparam int WS_WIDTH   = 3;

    // ==========================================================
    // Wait-state thresholds
    localparam logic [WS_WIDTH-1:0] WS_NONE        = 3'h0;
    localparam logic [WS_WIDTH-1:0] WS_ONE         = 3'h1;
    localparam logic [WS_WIDTH-1:0] WS_TWO         = 3'h2;
    localparam logic [WS_WIDTH-1:0] READY_MIN_WAIT = 3'h2;

    // ==========================================================
    // Reset values
    localparam logic [ADDR_WIDTH-1:0] ADDR_RESET = 23'h000000;
    localparam logic [DATA_WIDTH-1:0] DATA_RESET = 16'h0000;

    // ==========================================================
    // Access spaces
    typedef enum logic [1:0] {
        SPACE_DATA    = 2'h0,
        SPACE_PROGRAM = 2'h1,
        SPACE_IO      = 2'h2
    } space_t;

    // ==========================================================
    // Bus sequencer states
    typedef enum logic [5:0] {
        S_IDLE  = 6'b000001,
        S_ADDR  = 6'b000010,
        S_WAIT  = 6'b000100,
        S_CHECK = 6'b001000,
        S_END   = 6'b010000,
        S_HOLD  = 6'b100000
    } bus_state_t;

    // ==========================================================
    // Core-side access request
    typedef struct packed {
        space_t                space;
        logic                  write;
        logic                  fetch;
        logic [ADDR_WIDTH-1:0] addr;
        logic [DATA_WIDTH-1:0] wdata;
    } bus_request_t;

    // ==========================================================
    // Control pin group, all inactive high
    typedef struct packed {
        logic data_space_select_n;
        logic program_space_select_n;
        logic io_space_select_n;
        logic memory_strobe_n;
        logic io_strobe_n;
        logic read_write;
    } ctrl_pins_t;

    localparam ctrl_pins_t CTRL_IDLE = 6'h3f;

    // ==========================================================
    // Software wait settings, one per access type
    typedef struct packed {
        logic [WS_WIDTH-1:0] data_waits;
        logic [WS_WIDTH-1:0] program_waits;
        logic [WS_WIDTH-1:0] io_waits;
    } wait_setting_t;

endpackage

// ==== src/external_bus_control.sv ====
`timescale 1ns/1ps
// Function
// - Space selects idle high; only the accessed space's select goes low.
// - A select is low exactly while the address is valid on the pins.
// - Memory strobe low only for external data or program memory access.
// - I/O strobe low only for external I/O access.
// - Direction line high for read, low only during a write.
// - Ready low means wait one cycle and sample again until high.
// - Ready is looked at only with two or more software wait states.
// - Ready is not sampled before all software wait states finish.
// - Master requests hold; after acknowledge the bus lines float.
// - Hold acknowledge low only in hold with lines released.
// - In hold, selects, strobes and direction line float.
// - Output-disable low floats all control and status outputs.
// - Wait-complete low at first wait state when there are two or more, high at last one.
// - Wait-complete looped to ready adds no external wait; it is high when ready is sampled.
// - Instruction-acquire low while a fetch address is on the bus.
// - Address lines float in hold and while output-disable is low.
// - Data lines float unless writing, and during reset or hold.
module external_bus_control
    import ext_bus_pkg::*;
#(
    parameter int AW = ext_bus_pkg::ADDR_WIDTH,
    parameter int DW = ext_bus_pkg::DATA_WIDTH
) (
    // Clock and reset
    input  wire logic                       clock,
    input  wire logic                       rst_b,
    // Core request side
    input  wire logic                       req_valid,
    input  wire ext_bus_pkg::bus_request_t  request,
    input  wire ext_bus_pkg::wait_setting_t wait_setting,
    output logic                            bus_busy,
    output logic                            access_done,
    output logic [DW-1:0]                   read_data,
    // Control pins
    output ext_bus_pkg::ctrl_pins_t         ctrl_pins,
    output logic                            ctrl_oe,
    // Address pins
    output logic [AW-1:0]                   addr_out,
    output logic                            addr_oe,
    // Data pins
    input  wire logic [DW-1:0]              data_in,
    output logic [DW-1:0]                   data_out,
    output logic                            data_oe,
    // Handshake and status pins
    input  wire logic                       ready,
    input  wire logic                       hold_request_n,
    input  wire logic                       output_disable_n,
    output logic                            hold_acknowledge_n,
    output logic                            wait_complete_n,
    output logic                            instruction_acquire_n,
    output logic                            status_oe
);
    import ext_bus_pkg::*;

    bus_state_t          state;
    bus_state_t          next_state;
    bus_request_t        active;
    logic [WS_WIDTH-1:0] active_waits;
    logic [WS_WIDTH-1:0] selected_waits;
    logic [WS_WIDTH-1:0] wait_count;
    logic                take;
    logic                in_access;
    logic                strobing;
    logic                ready_used;
    logic                next_wait_complete_n;
    bus_request_t        pin_source;

    // ==========================================================
    // Wait-state selection
    always_comb begin
        case (request.space)
            SPACE_DATA:    selected_waits = wait_setting.data_waits;
            SPACE_PROGRAM: selected_waits = wait_setting.program_waits;
            SPACE_IO:      selected_waits = wait_setting.io_waits;
            default:       selected_waits = WS_NONE;
        endcase
    end

    assign take       = (state == S_IDLE) && hold_request_n && req_valid;
    // Pins are loaded straight from request on the take edge itself, the same edge that latches it into active.
    assign pin_source = take ? request : active;
    assign ready_used = active_waits >= READY_MIN_WAIT;

    // ==========================================================
    // Sequencer
    always_comb begin
        next_state = state;
        case (state)
            S_IDLE: begin
                if (!hold_request_n) begin
                    next_state = S_HOLD;
                end else if (req_valid) begin
                    next_state = S_ADDR;
                end
            end
            S_ADDR: begin
                if (active_waits == WS_NONE) begin
                    next_state = S_END;
                end else begin
                    next_state = S_WAIT;
                end
            end
            S_WAIT: begin
                if (wait_count == WS_ONE) begin
                    // Ready sampling starts only after the last wait.
                    next_state = ready_used ? S_CHECK : S_END;
                end
            end
            S_CHECK: begin
                if (ready) begin
                    next_state = S_END;
                end
            end
            S_END: begin
                next_state = S_IDLE;
            end
            S_HOLD: begin
                if (hold_request_n) begin
                    next_state = S_IDLE;
                end
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            state <= S_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ==========================================================
    // Latched access
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            active       <= '0;
            active_waits <= WS_NONE;
        end else if (take) begin
            active       <= request;
            active_waits <= selected_waits;
        end
    end

    wait_state_counter #(
        .WIDTH (WS_WIDTH)
    ) u_wait_state_counter (
        .clock      (clock),
        .rst_b      (rst_b),
        .load       (state == S_ADDR),
        .load_value (active_waits),
        .step       (state == S_WAIT),
        .count      (wait_count)
    );

    // ==========================================================
    // Control and address pins
    // Pin registers are loaded from the next state so they change on
    // the same edge as the sequencer.
    assign in_access = (next_state == S_ADDR) || (next_state == S_WAIT)
                    || (next_state == S_CHECK) || (next_state == S_END);
    assign strobing  = (next_state == S_WAIT) || (next_state == S_CHECK)
                    || (next_state == S_END);

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            ctrl_pins             <= CTRL_IDLE;
            addr_out              <= ADDR_RESET;
            instruction_acquire_n <= 1'b1;
        end else begin
            ctrl_pins <= CTRL_IDLE;
            if (in_access) begin
                ctrl_pins.data_space_select_n    <= pin_source.space != SPACE_DATA;
                ctrl_pins.program_space_select_n <= pin_source.space != SPACE_PROGRAM;
                ctrl_pins.io_space_select_n      <= pin_source.space != SPACE_IO;
                ctrl_pins.read_write             <= !pin_source.write;
                ctrl_pins.memory_strobe_n        <= !(strobing
                                                   && pin_source.space != SPACE_IO);
                ctrl_pins.io_strobe_n            <= !(strobing
                                                   && pin_source.space == SPACE_IO);
                addr_out                         <= pin_source.addr;
            end
            instruction_acquire_n <= !(in_access && pin_source.fetch);
        end
    end

    // ==========================================================
    // Wait-complete output
    always_comb begin
        next_wait_complete_n = 1'b1;
        if (next_state == S_WAIT) begin
            if (state == S_ADDR) begin
                next_wait_complete_n = !(active_waits >= WS_TWO);
            end else begin
                // High again as the last wait state begins.
                next_wait_complete_n = (wait_count == WS_TWO) ? 1'b1
                                                              : wait_complete_n;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            wait_complete_n <= 1'b1;
        end else begin
            wait_complete_n <= next_wait_complete_n;
        end
    end

    // ==========================================================
    // Hold and output enables
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            hold_acknowledge_n <= 1'b1;
            ctrl_oe            <= 1'b0;
            addr_oe            <= 1'b0;
            status_oe          <= 1'b0;
        end else begin
            hold_acknowledge_n <= next_state != S_HOLD;
            ctrl_oe            <= output_disable_n && next_state != S_HOLD;
            addr_oe            <= output_disable_n && next_state != S_HOLD;
            status_oe          <= output_disable_n;
        end
    end

    // ==========================================================
    // Data pins
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            data_out <= DATA_RESET;
            data_oe  <= 1'b0;
        end else begin
            if (take) begin
                data_out <= request.wdata;
            end
            data_oe <= output_disable_n && hold_request_n
                    && in_access && pin_source.write;
        end
    end

    // ==========================================================
    // Core answer
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            bus_busy    <= 1'b0;
            access_done <= 1'b0;
            read_data   <= DATA_RESET;
        end else begin
            bus_busy    <= next_state != S_IDLE;
            access_done <= state == S_END;
            if (state == S_END && !active.write) begin
                read_data <= data_in;
            end
        end
    end

endmodule

// ==== src/wait_state_counter.sv ====
`timescale 1ns/1ps
module wait_state_counter #(
    parameter int WIDTH = ext_bus_pkg::WS_WIDTH
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst_b,
    // Control
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_value,
    input  wire logic             step,
    // Remaining wait states
    output logic      [WIDTH-1:0] count
);
    import ext_bus_pkg::*;

    localparam logic [WIDTH-1:0] ZERO = '0;
    localparam logic [WIDTH-1:0] ONE  = {{(WIDTH-1){1'b0}}, 1'b1};

    // ==========================================================
    // Down counter
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            count <= ZERO;
        end else if (load) begin
            count <= load_value;
        end else if (step && count != ZERO) begin
            count <= count - ONE;
        end
    end

endmodule
